/* design/pll_host_consts.vh */
// Purpose: constants for the synthesizer programming controller
// Assumes: device registers are byte wide, software registers 32 bits wide
// Notes: definitions only
`ifndef PLL_HOST_CONSTS_VH
`define PLL_HOST_CONSTS_VH

// device register addresses
`define DEV_MAIN_CTRL_ADDR 8'h36
`define DEV_BANDWIDTH_ADDR 8'h37
`define DEV_MUL_HIGH_ADDR 8'h38
`define DEV_MUL_LOW_ADDR 8'h39
`define DEV_VCO_RANGE_ADDR 8'h3A
`define DEV_REF_DIV_ADDR 8'h3B

// main control register field positions
`define MAIN_POWER_ON_BIT 5
`define MAIN_BASE_SELECT_BIT 4
`define MAIN_PRESCALE_LSB 2
`define MAIN_RANGE_POWER_LSB 0

// software register offsets
`define SW_COMMAND_ADDR 3'h0
`define SW_MULTIPLIER_ADDR 3'h1
`define SW_SETUP_ADDR 3'h2
`define SW_STATUS_ADDR 3'h3
`define SW_REF_FREQ_ADDR 3'h4

// command bits (write one to act)
`define CMD_START_BIT 0
`define CMD_SELECT_VCO_BIT 1
`define CMD_STOP_BIT 2

// setup register fields
`define SETUP_LINEAR_LSB 0
`define SETUP_REF_DIV_LSB 8
`define SETUP_PRESCALE_LSB 12
`define SETUP_RANGE_POWER_LSB 14

// status register bits
`define STAT_BUSY_BIT 0
`define STAT_RANGE_ERR_BIT 1
`define STAT_CENTRE_ERR_BIT 2
`define STAT_POWER_ON_BIT 3
`define STAT_VCO_ACTIVE_BIT 4
`define STAT_LINEAR_ZERO_BIT 5

// reset values
`define RST_MULTIPLIER 12'h040
`define RST_LINEAR 8'h40
`define RST_REF_DIV 4'h1
`define RST_REF_FREQ_HZ 17'h08000

// frequencies in Hz
`define NOMINAL_FREQ_HZ 40'd38400
`define HALF_NOMINAL_HZ 40'd19200
`define RANGE_STEP_HZ 40'd4000000
`define BUS_TO_VCO_FACTOR 4

// timing
`define CLK_FREQ_MHZ 10
`define SETTLE_TIME_US 20000
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLK_FREQ_MHZ)

`endif

/* design/wait_timer.v */
// Purpose: down counter that times the loop settling wait
// Assumes: start is a one-cycle pulse
// Notes: done is a level while idle after expiry
`timescale 1ns/10ps
module wait_timer #(
    parameter W = 24
) (
    input wire clk_i,
    input wire reset_i,
    input wire start_i,
    input wire [W-1:0] length_i,
    output wire done_o
);
    reg [W-1:0] count_r;
    reg run_r;

    // counts length cycles after the start pulse
    always @(posedge clk_i) begin
        if (reset_i) begin
            count_r <= {W{1'b0}};
            run_r <= 1'b0;
        end else if (start_i) begin
            count_r <= length_i;
            run_r <= 1'b1;
        end else if (run_r) begin
            if (count_r <= {{(W-1){1'b0}}, 1'b1}) begin
                run_r <= 1'b0;
            end
            count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_o = ~run_r & ~start_i;
endmodule

/* design/pll_check.v */
// Purpose: checks a setting against the range and centre limits
// Assumes: all inputs steady for one cycle before the result is used
// Notes: all sums are scaled by the reference divider to avoid division
`timescale 1ns/10ps
`include "pll_host_consts.vh"
module pll_check (
    input wire clk_i,
    input wire reset_i,
    input wire [11:0] mult_i,
    input wire [3:0] ref_div_i,
    input wire [1:0] prescale_i,
    input wire [1:0] range_power_i,
    input wire [7:0] linear_i,
    input wire [16:0] ref_freq_i,
    output reg range_err_o,
    output reg centre_err_o
);
    reg [39:0] ref_div_eff;
    reg [39:0] mult_eff;
    reg [39:0] vco_times_r;
    reg [39:0] centre_times_r;
    reg [39:0] diff;
    reg [39:0] lo_lim;
    reg [39:0] hi_lim;
    reg range_bad;
    reg centre_bad;

    // every quantity is the real frequency times the reference divider
    always @* begin
        // [R10] zero divider or multiplier counts as one
        ref_div_eff = (ref_div_i == 4'h0) ? 40'd1 : {36'd0, ref_div_i};
        mult_eff = (mult_i == 12'h000) ? 40'd1 : {28'd0, mult_i};
        // [R2] vco frequency relation
        vco_times_r = (mult_eff << prescale_i) * {23'd0, ref_freq_i};
        // [R5] linear factor times nominal
        centre_times_r = (({32'd0, linear_i} * `NOMINAL_FREQ_HZ) << range_power_i) * ref_div_eff;
        diff = (vco_times_r > centre_times_r) ? vco_times_r - centre_times_r
                                              : centre_times_r - vco_times_r;
        // [R6] centre within half a step
        centre_bad = diff > ((`HALF_NOMINAL_HZ << range_power_i) * ref_div_eff);
        lo_lim = (range_power_i == 2'd0) ? 40'd0
                                         : (`RANGE_STEP_HZ << range_power_i) * ref_div_eff;
        hi_lim = ((`RANGE_STEP_HZ << 1) << range_power_i) * ref_div_eff;
        // [R4] range power band, three never allowed
        // [R1] the 32 MHz ceiling bounds the bus at a quarter of it
        range_bad = (range_power_i == 2'd3) || (vco_times_r < lo_lim) ||
                    (vco_times_r >= hi_lim);
    end

    // registered so the verdicts are flop outputs
    always @(posedge clk_i) begin
        if (reset_i) begin
            range_err_o <= 1'b0;
            centre_err_o <= 1'b0;
        end else begin
            range_err_o <= range_bad;
            centre_err_o <= centre_bad;
        end
    end
endmodule

/* design/pll_host.v */
// Purpose: controller that programs the synthesizer and its base clock select
// Assumes: device register port is synchronous to clk_i, read data one cycle after read
// Notes: software gives P, N, R, E, L; this block orders the device writes safely
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
`include "pll_host_consts.vh"

// Notes on behaviour
// [R1] software aims the vco at four times the wanted bus rate
// [R2] vco equals reference times two to P times N over R
// [R3] software picks P 0..3 from how far N exceeds its maximum
// [R4] range power 0, 1, 2 by vco band; value 3 is refused
// [R5] linear factor is vco over two to E times 38.4 kHz
// [R6] centre frequency must be within half a step of the vco
// [R7] P and E go into the main control register fields
// [R8] N is split over the high and low multiplier registers
// [R9] L and R go to the range and reference divider registers
// [R10] device reads a zero R or N as one
// [R11] zero L keeps the crystal clock; vco never selected
// [R12] device holds its output still while switching sources
// [R13] device halves the selected clock for a balanced duty
// [R14] vco cannot be selected while the loop is off
// [R15] loop cannot be switched off while the vco is selected
// [R16] power and source select never change in one write
// [R17] a 32.768 kHz reference with R of one is preferred
// [R18] vco should be an integer multiple of reference over R
// [R19] source select forced low while off or L is zero
// [R20] programming registers are read-only while the loop is on
// [R21] device synchronises source switching per clock domain
module pll_host #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire clk_i,
    input wire reset_i,
    input wire [2:0] sw_addr_i,
    input wire [31:0] sw_wdata_i,
    input wire sw_wr_i,
    input wire sw_rd_i,
    output reg [31:0] sw_rdata_o,
    output reg [7:0] dev_addr_o,
    output reg [7:0] dev_wdata_o,
    output reg dev_wr_o,
    output reg dev_rd_o,
    input wire [7:0] dev_rdata_i
);
    localparam S_IDLE = 4'd0;
    localparam S_DESELECT = 4'd1;
    localparam S_POWER_OFF = 4'd2;
    localparam S_MUL_HIGH = 4'd3;
    localparam S_MUL_LOW = 4'd4;
    localparam S_RANGE = 4'd5;
    localparam S_REF_DIV = 4'd6;
    localparam S_POWER_ON = 4'd7;
    localparam S_SETTLE = 4'd8;
    localparam S_SELECT = 4'd9;
    localparam S_READ_BACK = 4'd10;
    localparam S_CAPTURE = 4'd11;
    localparam S_READ_WAIT = 4'd12;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [11:0] mult_r;
    reg [7:0] linear_r;
    reg [3:0] ref_div_r;
    reg [1:0] prescale_r;
    reg [1:0] range_power_r;
    reg [16:0] ref_freq_r;
    reg want_vco_r;
    reg stopping_r;
    reg power_on_r;
    reg vco_active_r;
    reg [7:0] addr_nxt;
    reg [7:0] wdata_nxt;
    reg wr_nxt;
    reg rd_nxt;
    reg timer_start;
    wire range_err;
    wire centre_err;
    wire timer_done;
    wire cmd_wr;
    wire start_ok;
    wire [7:0] main_off_word;
    wire [7:0] main_on_word;
    wire [7:0] main_sel_word;

    assign cmd_wr = sw_wr_i && (sw_addr_i == `SW_COMMAND_ADDR);
    // a bad setting never starts a sequence; a stop still writes its P and E to the main control register
    assign start_ok = ~range_err & ~centre_err;

    // [R7] prescale and range power in the main word
    // [R16] each word changes either power or select, not both
    assign main_off_word = ({6'd0, prescale_r} << `MAIN_PRESCALE_LSB) |
                           ({6'd0, range_power_r} << `MAIN_RANGE_POWER_LSB);
    assign main_on_word = main_off_word | (8'h01 << `MAIN_POWER_ON_BIT);
    assign main_sel_word = main_on_word | (8'h01 << `MAIN_BASE_SELECT_BIT);

    pll_check check_unit (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .mult_i(mult_r),
        .ref_div_i(ref_div_r),
        .prescale_i(prescale_r),
        .range_power_i(range_power_r),
        .linear_i(linear_r),
        .ref_freq_i(ref_freq_r),
        .range_err_o(range_err),
        .centre_err_o(centre_err)
    );

    wait_timer #(.W(24)) settle_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(timer_start),
        .length_i(SETTLE_CYCLES[23:0]),
        .done_o(timer_done)
    );

    // software setup registers; frozen while a sequence runs
    always @(posedge clk_i) begin
        if (reset_i) begin
            mult_r <= `RST_MULTIPLIER;
            linear_r <= `RST_LINEAR;
            // [R17] reference divider of one by default
            ref_div_r <= `RST_REF_DIV;
            prescale_r <= 2'h0;
            range_power_r <= 2'h0;
            ref_freq_r <= `RST_REF_FREQ_HZ;
        end else if (sw_wr_i && state_r == S_IDLE) begin
            case (sw_addr_i)
                `SW_MULTIPLIER_ADDR: begin
                    // [R18] integer multiplier only
                    mult_r <= sw_wdata_i[11:0];
                end
                `SW_SETUP_ADDR: begin
                    linear_r <= sw_wdata_i[`SETUP_LINEAR_LSB +: 8];
                    ref_div_r <= sw_wdata_i[`SETUP_REF_DIV_LSB +: 4];
                    // [R3] prescale chosen by software
                    prescale_r <= sw_wdata_i[`SETUP_PRESCALE_LSB +: 2];
                    range_power_r <= sw_wdata_i[`SETUP_RANGE_POWER_LSB +: 2];
                end
                `SW_REF_FREQ_ADDR: begin
                    ref_freq_r <= sw_wdata_i[16:0];
                end
                default: begin
                end
            endcase
        end
    end

    // sequencer: next state and the device access of the next cycle
    always @* begin
        state_nxt = state_r;
        addr_nxt = `DEV_MAIN_CTRL_ADDR;
        wdata_nxt = 8'h00;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        timer_start = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (cmd_wr && sw_wdata_i[`CMD_STOP_BIT]) begin
                    state_nxt = S_DESELECT;
                end else if (cmd_wr && sw_wdata_i[`CMD_START_BIT] && start_ok) begin
                    state_nxt = S_DESELECT;
                end
            end
            S_DESELECT: begin
                // [R15] drop the vco select before power
                wdata_nxt = main_on_word;
                wr_nxt = 1'b1;
                state_nxt = S_POWER_OFF;
            end
            S_POWER_OFF: begin
                // [R20] programming needs the loop off
                wdata_nxt = main_off_word;
                wr_nxt = 1'b1;
                state_nxt = stopping_r ? S_IDLE : S_MUL_HIGH;
            end
            S_MUL_HIGH: begin
                // [R8] upper multiplier bits
                addr_nxt = `DEV_MUL_HIGH_ADDR;
                wdata_nxt = {4'h0, mult_r[11:8]};
                wr_nxt = 1'b1;
                state_nxt = S_MUL_LOW;
            end
            S_MUL_LOW: begin
                addr_nxt = `DEV_MUL_LOW_ADDR;
                wdata_nxt = mult_r[7:0];
                wr_nxt = 1'b1;
                state_nxt = S_RANGE;
            end
            S_RANGE: begin
                // [R9] linear factor then divider
                addr_nxt = `DEV_VCO_RANGE_ADDR;
                wdata_nxt = linear_r;
                wr_nxt = 1'b1;
                state_nxt = S_REF_DIV;
            end
            S_REF_DIV: begin
                addr_nxt = `DEV_REF_DIV_ADDR;
                wdata_nxt = {4'h0, ref_div_r};
                wr_nxt = 1'b1;
                state_nxt = S_POWER_ON;
            end
            S_POWER_ON: begin
                // [R14] power first, select later
                wdata_nxt = main_on_word;
                wr_nxt = 1'b1;
                timer_start = 1'b1;
                state_nxt = S_SETTLE;
            end
            S_SETTLE: begin
                // [R11] zero linear factor never asks for the vco
                if (timer_done) begin
                    state_nxt = (want_vco_r && linear_r != 8'h00) ? S_SELECT : S_IDLE;
                end
            end
            S_SELECT: begin
                // [R16] select alone, power already on
                wdata_nxt = main_sel_word;
                wr_nxt = 1'b1;
                state_nxt = S_READ_BACK;
            end
            S_READ_BACK: begin
                rd_nxt = 1'b1;
                state_nxt = S_READ_WAIT;
            end
            S_READ_WAIT: begin
                // device answers in the cycle after its read strobe
                state_nxt = S_CAPTURE;
            end
            S_CAPTURE: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // device port outputs come from flops one cycle after the decision
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= S_IDLE;
            dev_addr_o <= `DEV_MAIN_CTRL_ADDR;
            dev_wdata_o <= 8'h00;
            dev_wr_o <= 1'b0;
            dev_rd_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dev_addr_o <= addr_nxt;
            dev_wdata_o <= wdata_nxt;
            dev_wr_o <= wr_nxt;
            dev_rd_o <= rd_nxt;
        end
    end

    // tracked device state; power comes up on at reset like the device
    always @(posedge clk_i) begin
        if (reset_i) begin
            want_vco_r <= 1'b0;
            stopping_r <= 1'b0;
            power_on_r <= 1'b1;
            vco_active_r <= 1'b0;
        end else begin
            if (state_r == S_IDLE && cmd_wr) begin
                want_vco_r <= sw_wdata_i[`CMD_SELECT_VCO_BIT];
                stopping_r <= sw_wdata_i[`CMD_STOP_BIT];
            end
            if (wr_nxt && addr_nxt == `DEV_MAIN_CTRL_ADDR) begin
                power_on_r <= wdata_nxt[`MAIN_POWER_ON_BIT];
            end
            // [R19] device may refuse the select; trust its readback
            if (state_r == S_DESELECT) begin
                vco_active_r <= 1'b0;
            end else if (state_r == S_CAPTURE) begin
                vco_active_r <= dev_rdata_i[`MAIN_BASE_SELECT_BIT];
            end
        end
    end

    // software read port, data in the cycle after the strobe
    always @(posedge clk_i) begin
        if (reset_i) begin
            sw_rdata_o <= 32'h00000000;
        end else if (sw_rd_i) begin
            case (sw_addr_i)
                `SW_MULTIPLIER_ADDR: sw_rdata_o <= {20'h00000, mult_r};
                `SW_SETUP_ADDR: sw_rdata_o <= {16'h0000, range_power_r, prescale_r,
                                               ref_div_r, linear_r};
                `SW_STATUS_ADDR: sw_rdata_o <= {26'h0000000, linear_r == 8'h00,
                                                vco_active_r, power_on_r, centre_err,
                                                range_err, state_r != S_IDLE};
                `SW_REF_FREQ_ADDR: sw_rdata_o <= {15'h0000, ref_freq_r};
                default: sw_rdata_o <= 32'h00000000;
            endcase
        end else begin
            sw_rdata_o <= 32'h00000000;
        end
    end
endmodule

/* bench/dev_model.sv */
// Purpose: synthesizer register set seen by the controller
// Assumes: one-cycle strobes, read data the cycle after a read
// Notes: no clocks modelled, only register protection, frequency figures and the source switch
`timescale 1ns/10ps
module dev_model (
    input wire clk_i,
    input wire reset_i,
    input wire [7:0] dev_addr_i,
    input wire [7:0] dev_wdata_i,
    input wire dev_wr_i,
    input wire dev_rd_i,
    output reg [7:0] dev_rdata_o
);
    reg [7:0] ctrl_r, mul_hi_r, mul_lo_r, range_r, refdiv_r;
    reg src_vco_r;
    reg [1:0] hold_r;
    wire [7:0] wd = dev_wdata_i;
    wire [11:0] raw_n = {mul_hi_r[3:0], mul_lo_r};
    // zero divider or multiplier reads as one
    wire [11:0] eff_n = (raw_n == 12'h000) ? 12'h001 : raw_n;
    wire [3:0] eff_r = (refdiv_r[3:0] == 4'h0) ? 4'h1 : refdiv_r[3:0];
    // vco from a 32.768 kHz reference, two to P times N over R
    wire [31:0] vco_hz = ({20'd0, eff_n} << ctrl_r[3:2]) * 32'd32768 / {28'd0, eff_r};
    // bus runs at a quarter of the selected source
    wire [31:0] bus_hz = (src_vco_r ? vco_hz : 32'd32768) >> 2;
    // register file; stale read data inverted each cycle so it looks wrong one cycle late
    always @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_r <= 8'h20;
            mul_hi_r <= 8'h00;
            mul_lo_r <= 8'h40;
            range_r <= 8'h40;
            refdiv_r <= 8'h01;
            dev_rdata_o <= 8'h00;
        end else begin
            dev_rdata_o <= dev_rd_i ? ctrl_r : ~dev_rdata_o;
            if (dev_wr_i && dev_addr_i == 8'h36) begin
                ctrl_r[3:0] <= wd[3:0];
                // power held while selected or select moves
                if (!ctrl_r[4] && wd[4] == ctrl_r[4])
                    ctrl_r[5] <= wd[5];
                // select needs loop on and nonzero range
                if (ctrl_r[5] && range_r != 8'h00 && wd[5])
                    ctrl_r[4] <= wd[4];
            end
            if (dev_wr_i && !ctrl_r[5]) begin
                case (dev_addr_i)
                    8'h38: mul_hi_r <= {4'h0, wd[3:0]};
                    8'h39: mul_lo_r <= wd;
                    8'h3A: range_r <= wd;
                    8'h3B: refdiv_r <= {4'h0, wd[3:0]};
                    default: ;
                endcase
            end
        end
    end

    // source follows the select after three cycles of stasis
    always @(posedge clk_i) begin
        if (reset_i) begin
            src_vco_r <= 1'b0;
            hold_r <= 2'd0;
        end else if (src_vco_r != ctrl_r[4]) begin
            hold_r <= hold_r + 2'd1;
            if (hold_r == 2'd2)
                src_vco_r <= ctrl_r[4];
        end else begin
            hold_r <= 2'd0;
        end
    end
endmodule

/* bench/pll_host_props.sv */
// Purpose: port checker for the synthesizer controller
// Assumes: single clock domain
// Notes: bound to every controller instance
`timescale 1ns/10ps
module pll_host_chk (
    input wire clk_i,
    input wire reset_i,
    input wire sw_rd_i,
    input wire [31:0] sw_rdata_o,
    input wire [7:0] dev_addr_o,
    input wire [7:0] dev_wdata_o,
    input wire dev_wr_o,
    input wire dev_rd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reg off_r, desel_r;
    // previous device write kinds, for ordering checks
    always @(posedge clk_i) begin
        off_r <= dev_wr_o && dev_addr_o == 8'h36 && !dev_wdata_o[5];
        desel_r <= dev_wr_o && dev_addr_o == 8'h36 && dev_wdata_o[5:4] == 2'b10;
    end
    wire wr36 = dev_wr_o && dev_addr_o == 8'h36;
    rd_idle_zero_a: assert property (!$past(sw_rd_i) |-> sw_rdata_o == 32'h0)
        else $error("read data not zero outside answer cycle");
    strobe_excl_a: assert property (!(dev_wr_o && dev_rd_o))
        else $error("device read and write together");
    wdata_idle_a: assert property (!dev_wr_o |-> dev_wdata_o == 8'h00)
        else $error("device write data not zero when idle");
    addr_idle_a: assert property (!dev_wr_o && !dev_rd_o |-> dev_addr_o == 8'h36)
        else $error("device address not idle value");
    mul_split_a: assert property (dev_wr_o && dev_addr_o == 8'h38 |->
        dev_wdata_o[7:4] == 4'h0 ##1 dev_wr_o && dev_addr_o == 8'h39)
        else $error("multiplier halves out of order");
    prog_locked_a: assert property (dev_wr_o && dev_addr_o == 8'h38 |-> off_r)
        else $error("multiplier written with loop on");
    loop_back_on_a: assert property (dev_wr_o && dev_addr_o == 8'h3B |->
        dev_wdata_o[7:4] == 4'h0 ##1 wr36 && dev_wdata_o[5:4] == 2'b10)
        else $error("loop not restarted after reference divider");
    select_power_a: assert property (wr36 && dev_wdata_o[4] |-> dev_wdata_o[5])
        else $error("select written with loop off");
    deselect_first_a: assert property (wr36 && !dev_wdata_o[5] |-> desel_r)
        else $error("loop off without prior deselect");
    select_check_a: assert property (wr36 && dev_wdata_o[4] |=>
        dev_rd_o && dev_addr_o == 8'h36)
        else $error("select not read back");
endmodule
bind pll_host pll_host_chk chk (.clk_i(clk_i), .reset_i(reset_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o), .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o),
    .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o));

/* bench/tb_top.sv */
// Purpose: self-checking bench for the synthesizer controller
// Assumes: short settle count so each start finishes quickly
// Notes: read results are queued by the driver and checked by a monitor
`timescale 1ns/10ps
module tb_top;
    reg clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [2:0] sw_addr_i = 3'h0;
    reg [31:0] sw_wdata_i = 32'h0;
    reg sw_wr_i = 1'b0;
    reg sw_rd_i = 1'b0;
    wire [31:0] sw_rdata_o;
    wire [7:0] dev_addr_o, dev_wdata_o, dev_rdata_i;
    wire dev_wr_o, dev_rd_o;
    logic [31:0] exp_q[$], mask_q[$];
    logic [31:0] last_rd = 32'h0;
    logic [31:0] rng = 32'd34092;
    reg rd_seen = 1'b0;
    integer num_errors = 0;
    integer checked = 0;
    always #50 clk_i = ~clk_i;
    pll_host #(.SETTLE_CYCLES(8)) dut (.clk_i(clk_i), .reset_i(reset_i), .sw_addr_i(sw_addr_i),
        .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
        .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_wr_o(dev_wr_o),
        .dev_rd_o(dev_rd_o), .dev_rdata_i(dev_rdata_i));
    dev_model dev (.clk_i(clk_i), .reset_i(reset_i), .dev_addr_i(dev_addr_o),
        .dev_wdata_i(dev_wdata_o), .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o),
        .dev_rdata_o(dev_rdata_i));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp_read(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
        checked++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("BAD sw_rdata_o expected %h seen %h", e & m, g & m);
        end
    endtask
    task automatic cmp_dev(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic sw_write(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        sw_wr_i <= 1'b1;
        sw_addr_i <= a;
        sw_wdata_i <= d;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
    endtask
    // a zero mask marks a poll read that is not compared
    task automatic sw_read(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        sw_rd_i <= 1'b1;
        sw_addr_i <= a;
        exp_q.push_back(e);
        mask_q.push_back(m);
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
    endtask
    task automatic wait_idle();
        integer n;
        n = 0;
        last_rd = 32'h1;
        while (last_rd[0] !== 1'b0 && n < 100) begin
            sw_read(3'h3, 32'h0, 32'h0);
            // the monitor takes the answer one edge later; look after it
            repeat (2) @(posedge clk_i);
            n++;
        end
        if (n >= 100) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // answer stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) begin
            last_rd = sw_rdata_o;
            if (mask_q[0] != 32'h0)
                cmp_read(exp_q[0], mask_q[0], sw_rdata_o);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
        rd_seen <= sw_rd_i;
    end
    // cut a hang well past the expected run length
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset setting is off centre, so the centre flag stands
        sw_read(3'h3, 32'h0C, 32'hFFFFFFFF);
        rng = xorshift(rng);
        sw_write(3'h5, rng);
        sw_read(3'h5, 32'h0, 32'hFFFFFFFF);
        sw_read(3'h0, 32'h0, 32'hFFFFFFFF);
        // band one, centre exact: start and select the vco
        sw_write(3'h1, 32'h12C);
        sw_write(3'h2, 32'h4180);
        repeat (2) @(posedge clk_i);
        sw_read(3'h3, 32'h08, 32'h07);
        sw_write(3'h0, 32'h3);
        wait_idle();
        cmp_dev("mul_hi", 8'h01, dev.mul_hi_r);
        cmp_dev("mul_lo", 8'h2C, dev.mul_lo_r);
        cmp_dev("range", 8'h80, dev.range_r);
        cmp_dev("refdiv", 8'h01, dev.refdiv_r);
        cmp_dev("ctrl", 8'h31, dev.ctrl_r);
        cmp_dev("vco_hz", 32'd9830400, dev.vco_hz);
        cmp_dev("bus_hz", 32'd2457600, dev.bus_hz);
        cmp_dev("source", 32'h1, dev.src_vco_r);
        sw_read(3'h3, 32'h18, 32'h3F);
        // stop deselects first, then powers down
        sw_write(3'h0, 32'h4);
        wait_idle();
        cmp_dev("ctrl", 8'h01, dev.ctrl_r);
        cmp_dev("bus_hz", 32'd8192, dev.bus_hz);
        sw_read(3'h3, 32'h0, 32'h18);
        // zero L and zero R: R acts as one, L flagged
        sw_write(3'h2, 32'h4000);
        repeat (2) @(posedge clk_i);
        sw_read(3'h3, 32'h24, 32'h27);
        // range power three is refused, start ignored
        sw_write(3'h2, 32'hC080);
        repeat (2) @(posedge clk_i);
        sw_read(3'h3, 32'h02, 32'h03);
        sw_write(3'h0, 32'h1);
        repeat (20) @(posedge clk_i);
        cmp_dev("ctrl", 8'h01, dev.ctrl_r);
        repeat (3) @(posedge clk_i);
        give_verdict();
    end
endmodule
